// *** hdl/sfb_pkg.sv ***
// Package for the status flags and bank select block.
// Assumes one 10 MHz core clock and an 8-bit data memory address space.
package sfb_pkg;
    localparam logic [7:0] CORE_STATUS_FLAGS_ADDR = 8'h03;
    localparam logic [7:0] CORE_STATUS_FLAGS_MIRROR = 8'h83;
    localparam logic [6:0] STATUS_LOW_ADDR = 7'h03;
    localparam int INDIRECT_BANK_POS = 7;
    localparam int DIRECT_HI_POS = 6;
    localparam int DIRECT_LO_POS = 5;
    localparam int TIMEOUT_POS = 4;
    localparam int POWERDOWN_POS = 3;
    localparam int ZERO_POS = 2;
    localparam int DIGIT_CARRY_POS = 1;
    localparam int CARRY_POS = 0;
    localparam int NIBBLE_WIDTH = 4;
    localparam logic [2:0] BANK_RESET = 3'h0;
    localparam logic TIMEOUT_RESET = 1'h1;
    localparam logic POWERDOWN_RESET = 1'h1;
    localparam logic [2:0] ARITH_RESET = 3'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] READ_DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        SFB_OP_NONE = 3'h0,
        SFB_OP_ADD = 3'h1,
        SFB_OP_SUB = 3'h3,
        SFB_OP_LOGIC = 3'h2,
        SFB_OP_ROT_LEFT = 3'h6,
        SFB_OP_ROT_RIGHT = 3'h7
    } sfb_op_type;
endpackage

// *** hdl/sfb_alu_flags.sv ***
// Flag computation for one ALU operation, purely combinational.
// Assumes operands and operation code are valid in the same cycle.
module sfb_alu_flags #(
    parameter int WIDTH = 8
) (
    input wire sfb_pkg::sfb_op_type op,
    input wire logic [WIDTH-1:0] operandA,
    input wire logic [WIDTH-1:0] operandB,
    input wire logic carryIn,
    output logic [WIDTH-1:0] result,
    output logic zeroOut,
    output logic digitCarryOut,
    output logic carryOut
);
    if (WIDTH <= sfb_pkg::NIBBLE_WIDTH) begin : g_width_check
        $error("WIDTH must exceed the nibble width");
    end

    logic [WIDTH:0] sum;
    logic [sfb_pkg::NIBBLE_WIDTH:0] nibbleSum;
    logic [WIDTH-1:0] addend;

    always_comb begin
        addend = operandB;
        if (op == sfb_pkg::SFB_OP_SUB) begin
            addend = ~operandB;
        end
        sum = {1'h0, operandA} + {1'h0, addend}
            + {{WIDTH{1'h0}}, op == sfb_pkg::SFB_OP_SUB};
        nibbleSum = {1'h0, operandA[sfb_pkg::NIBBLE_WIDTH-1:0]}
            + {1'h0, addend[sfb_pkg::NIBBLE_WIDTH-1:0]}
            + {{sfb_pkg::NIBBLE_WIDTH{1'h0}},
               op == sfb_pkg::SFB_OP_SUB};
        result = operandA;
        digitCarryOut = 1'h0;
        carryOut = carryIn;
        case (op)
            sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB: begin
                result = sum[WIDTH-1:0];
                digitCarryOut = nibbleSum[sfb_pkg::NIBBLE_WIDTH];
                carryOut = sum[WIDTH];
            end
            sfb_pkg::SFB_OP_LOGIC: begin
                result = operandB;
            end
            sfb_pkg::SFB_OP_ROT_LEFT: begin
                result = {operandA[WIDTH-2:0], carryIn};
                carryOut = operandA[WIDTH-1];
            end
            sfb_pkg::SFB_OP_ROT_RIGHT: begin
                result = {carryIn, operandA[WIDTH-1:1]};
                carryOut = operandA[0];
            end
            default: begin
                result = operandA;
            end
        endcase
        zeroOut = (result == '0);
    end
endmodule // sfb_alu_flags

// *** hdl/sfb_status_flags.sv ***
// Core status register: arithmetic flags, reset cause bits, bank select.
// Assumes the core supplies one-cycle operation and event strobes.
// Operation
// - Time-out set by power-up, clear, sleep
// - Digit carry from fourth bit on add/sub
// - Carry from top bit on add/sub
// - Subtract adds two's complement; inverted borrow
// - Rotates load carry with shifted-out bit
// - Reset: banks 0, indicators 1
// - Register at 03h and mirror 83h
// - Flag writes blocked when flags updated
//
// Decided for this implementation: the address-and-strobe port.
module sfb_status_flags #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdData,
    input wire logic opValid,
    input wire sfb_pkg::sfb_op_type opCode,
    input wire logic [WIDTH-1:0] operandA,
    input wire logic [WIDTH-1:0] operandB,
    output logic [WIDTH-1:0] aluResult,
    input wire logic watchdogTimeout,
    input wire logic watchdogClearInstruction,
    input wire logic sleepInstruction,
    output logic indirectBankSelect,
    output logic [1:0] directBankSelect,
    output logic zeroFlag,
    output logic digitCarryFlag,
    output logic carryFlag,
    output logic timeoutIndicator,
    output logic powerdownIndicator
);
    if (WIDTH != 8) begin : g_width_check
        $error("WIDTH must be 8 for this core");
    end

    logic [WIDTH-1:0] result;
    logic zeroNext;
    logic digitCarryNext;
    logic carryNext;
    logic statusHit;
    logic flagOp;
    logic [7:0] statusView;

    sfb_alu_flags #(.WIDTH(WIDTH)) i_sfb_alu_flags (
        .op(opCode),
        .operandA(operandA),
        .operandB(operandB),
        .carryIn(carryFlag),
        .result(result),
        .zeroOut(zeroNext),
        .digitCarryOut(digitCarryNext),
        .carryOut(carryNext)
    );

    assign statusHit = (regAddr[6:0] == sfb_pkg::STATUS_LOW_ADDR);
    assign flagOp = opValid && (opCode != sfb_pkg::SFB_OP_NONE);
    assign statusView = {indirectBankSelect, directBankSelect,
        timeoutIndicator, powerdownIndicator, zeroFlag,
        digitCarryFlag, carryFlag};

    // Bank select bits
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {indirectBankSelect, directBankSelect} <= sfb_pkg::BANK_RESET;
        end else if (regWrite && statusHit) begin
            indirectBankSelect <= regWrData[sfb_pkg::INDIRECT_BANK_POS];
            directBankSelect <= regWrData[sfb_pkg::DIRECT_HI_POS:
                sfb_pkg::DIRECT_LO_POS];
        end
    end

    // Reset cause indicators, never software writable
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timeoutIndicator <= sfb_pkg::TIMEOUT_RESET;
            powerdownIndicator <= sfb_pkg::POWERDOWN_RESET;
        end else begin
            if (watchdogTimeout) begin
                timeoutIndicator <= 1'h0;
            end else if (watchdogClearInstruction || sleepInstruction) begin
                timeoutIndicator <= 1'h1;
            end
            if (sleepInstruction) begin
                powerdownIndicator <= 1'h0;
            end else if (watchdogClearInstruction) begin
                powerdownIndicator <= 1'h1;
            end
        end
    end

    // Arithmetic flags
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {zeroFlag, digitCarryFlag, carryFlag} <= sfb_pkg::ARITH_RESET;
        end else if (flagOp) begin
            zeroFlag <= zeroNext;
            if (opCode == sfb_pkg::SFB_OP_ADD
                    || opCode == sfb_pkg::SFB_OP_SUB) begin
                digitCarryFlag <= digitCarryNext;
                carryFlag <= carryNext;
            end else if (opCode == sfb_pkg::SFB_OP_ROT_LEFT
                    || opCode == sfb_pkg::SFB_OP_ROT_RIGHT) begin
                carryFlag <= carryNext;
            end
        end else if (regWrite && statusHit) begin
            zeroFlag <= regWrData[sfb_pkg::ZERO_POS];
            digitCarryFlag <= regWrData[sfb_pkg::DIGIT_CARRY_POS];
            carryFlag <= regWrData[sfb_pkg::CARRY_POS];
        end
    end

    // Registered ALU result
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            aluResult <= sfb_pkg::RESULT_RESET;
        end else if (flagOp) begin
            aluResult <= result;
        end
    end

    // Read port, data one cycle after strobe
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdData <= sfb_pkg::READ_DATA_RESET;
        end else if (regRead && statusHit) begin
            regRdData <= statusView;
        end else begin
            regRdData <= 8'h00;
        end
    end

    // Arithmetic flag checks
    a_zero_follows: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp |=> zeroFlag == (aluResult == '0))
        else $error("zero flag does not match result");
    a_logic_zero: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_LOGIC |=>
        zeroFlag == ($past(operandB) == '0))
        else $error("zero flag wrong for logic result");
    a_add_carry: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_ADD |=>
        carryFlag == (({1'h0, $past(operandA)} + {1'h0, $past(operandB)})
        >> WIDTH))
        else $error("add carry wrong");
    a_sub_borrow: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_SUB |=>
        carryFlag == ($past(operandA) >= $past(operandB)))
        else $error("subtract borrow polarity wrong");
    a_digit_carry: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_ADD |=>
        digitCarryFlag == ((($past(operandA) & 8'h0F)
        + ($past(operandB) & 8'h0F)) > 8'h0F))
        else $error("digit carry wrong");
    a_sub_digit: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_SUB |=>
        digitCarryFlag == ($past(operandA[3:0]) >= $past(operandB[3:0])))
        else $error("digit borrow polarity wrong");
    a_rot_left: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_ROT_LEFT |=>
        carryFlag == $past(operandA[WIDTH-1]))
        else $error("rotate left carry wrong");
    a_rot_right: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        flagOp && opCode == sfb_pkg::SFB_OP_ROT_RIGHT |=>
        carryFlag == $past(operandA[0]))
        else $error("rotate right carry wrong");

    // Indicator checks
    a_timeout_clear: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        watchdogTimeout |=> !timeoutIndicator)
        else $error("time-out not cleared");
    a_clear_sets: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        watchdogClearInstruction && !watchdogTimeout && !sleepInstruction
        |=> timeoutIndicator && powerdownIndicator)
        else $error("watchdog clear did not set indicators");
    a_sleep_powerdown: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        sleepInstruction |=> !powerdownIndicator
        && (timeoutIndicator || $past(watchdogTimeout)))
        else $error("sleep indicators wrong");
    a_indicator_nowrite: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !watchdogTimeout && !watchdogClearInstruction && !sleepInstruction
        |=> $stable(timeoutIndicator) && $stable(powerdownIndicator))
        else $error("indicator changed without event");

    // Register port checks
    a_mirror_read: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr == sfb_pkg::CORE_STATUS_FLAGS_MIRROR
        |=> regRdData == $past(statusView))
        else $error("mirror read wrong");
    a_other_read: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regRead && regAddr != sfb_pkg::CORE_STATUS_FLAGS_ADDR
        && regAddr != sfb_pkg::CORE_STATUS_FLAGS_MIRROR
        |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_bank_write: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == sfb_pkg::CORE_STATUS_FLAGS_ADDR |=>
        {indirectBankSelect, directBankSelect} == $past(regWrData[7:5]))
        else $error("bank bits not written");
    a_flag_write: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == sfb_pkg::CORE_STATUS_FLAGS_MIRROR && !flagOp
        |=> {zeroFlag, digitCarryFlag, carryFlag} == $past(regWrData[2:0]))
        else $error("flag bits not written");
    a_flag_blocked: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        regWrite && regAddr == sfb_pkg::CORE_STATUS_FLAGS_ADDR
        && flagOp && opCode == sfb_pkg::SFB_OP_LOGIC
        |=> digitCarryFlag == $past(digitCarryFlag)
        && carryFlag == $past(carryFlag))
        else $error("flag write not blocked by operation");
endmodule // sfb_status_flags

// *** tb/tb_sfb_status_flags.sv ***
// Self-checking bench for the status flags and bank select register.
// Assumes sfb_pkg is compiled first and the design keeps a 10 MHz clock.
module tb_sfb_status_flags;
    timeunit 1ns;
    timeprecision 1ns;
    logic refClk, arstN, regWrite, regRead, opValid;
    logic wdTo, wdClr, sleepIns, indirectBankSelect;
    logic zeroFlag, digitCarryFlag, carryFlag;
    logic timeoutIndicator, powerdownIndicator;
    logic [1:0] directBankSelect;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [7:0] operandA, operandB, aluResult, m, mRes, seen;
    logic [31:0] seed;
    logic [2:0] ev;
    sfb_pkg::sfb_op_type opCode;
    sfb_pkg::sfb_op_type ops [8] = '{sfb_pkg::SFB_OP_NONE,
        sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB, sfb_pkg::SFB_OP_LOGIC,
        sfb_pkg::SFB_OP_ROT_LEFT, sfb_pkg::SFB_OP_ROT_RIGHT,
        sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB};
    int errTotal, nTests;
    assign seen = {indirectBankSelect, directBankSelect, timeoutIndicator,
        powerdownIndicator, zeroFlag, digitCarryFlag, carryFlag};
    sfb_status_flags #(.WIDTH(8)) i_sfb_status_flags (.ref_clk(refClk),
        .arst_n(arstN), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .opValid(opValid), .opCode(opCode), .operandA(operandA),
        .operandB(operandB), .aluResult(aluResult), .watchdogTimeout(wdTo),
        .watchdogClearInstruction(wdClr), .sleepInstruction(sleepIns),
        .indirectBankSelect(indirectBankSelect),
        .directBankSelect(directBankSelect), .zeroFlag(zeroFlag),
        .digitCarryFlag(digitCarryFlag), .carryFlag(carryFlag),
        .timeoutIndicator(timeoutIndicator),
        .powerdownIndicator(powerdownIndicator));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    // Result and flags {res, zero, digit carry, carry}
    function automatic logic [10:0] aluExp(input sfb_pkg::sfb_op_type oc,
        input logic [7:0] a, b, input logic [2:0] f);
        logic [8:0] s;
        logic [4:0] h;
        logic [7:0] bb;
        logic sub;
        sub = (oc == sfb_pkg::SFB_OP_SUB);
        bb = sub ? ~b : b;
        s = {1'h0, a} + {1'h0, bb} + 9'(sub);
        h = {1'h0, a[3:0]} + {1'h0, bb[3:0]} + 5'(sub);
        case (oc)
            sfb_pkg::SFB_OP_ADD, sfb_pkg::SFB_OP_SUB:
                return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
            sfb_pkg::SFB_OP_ROT_LEFT:
                return {a[6:0], f[0], {a[6:0], f[0]} == 8'h00, f[1], a[7]};
            sfb_pkg::SFB_OP_ROT_RIGHT:
                return {f[0], a[7:1], {f[0], a[7:1]} == 8'h00, f[1], a[0]};
            default:
                return {b, b == 8'h00, f[1:0]};
        endcase
    endfunction
    task automatic chk(input string nm, input logic [7:0] exp, got);
        nTests++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            errTotal++;
        end
    endtask
    task automatic testDone;
        if (errTotal == 0 && nTests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic go(input logic w, r, input logic [7:0] ad, wd,
        input logic ov, input sfb_pkg::sfb_op_type oc,
        input logic [7:0] a, b, input logic [2:0] e);
        logic [7:0] rdExp;
        logic [10:0] x;
        logic act;
        logic hit;
        act = ov && oc != sfb_pkg::SFB_OP_NONE;
        hit = ad[6:0] == sfb_pkg::STATUS_LOW_ADDR;
        rdExp = (r && hit) ? m : 8'h00;
        @(posedge refClk);
        {regWrite, regRead, opValid, wdTo, wdClr, sleepIns} <= {w, r, ov, e};
        {regAddr, regWrData, operandA, operandB} <= {ad, wd, a, b};
        opCode <= oc;
        @(posedge refClk);
        {regWrite, regRead, opValid, wdTo, wdClr, sleepIns} <= 6'h00;
        #1;
        if (w && hit) begin
            m[7:5] = wd[7:5];
            m[2:0] = act ? m[2:0] : wd[2:0];
        end
        if (act) begin
            x = aluExp(oc, a, b, m[2:0]);
            {mRes, m[2:0]} = x;
        end
        m[4] = e[2] ? 1'h0 : ((e[1] | e[0]) ? 1'h1 : m[4]);
        m[3] = e[0] ? 1'h0 : (e[1] ? 1'h1 : m[3]);
        chk("status", m, seen);
        chk("alu result", mRes, aluResult);
        chk("read data", rdExp, regRdData);
    endtask
    initial begin
        refClk = 1'h0;
        forever #50 refClk = ~refClk;
    end
    initial begin
        repeat (5000) @(posedge refClk);
        errTotal++;
        testDone;
    end
    initial begin
        {arstN, regWrite, regRead, opValid, wdTo, wdClr, sleepIns} = 7'h00;
        {regAddr, regWrData, operandA, operandB} = 32'h0000_0000;
        opCode = sfb_pkg::SFB_OP_NONE;
        {errTotal, nTests, seed, m, mRes} = {32'h0, 32'h0, 32'h179AC, 16'h1800};
        repeat (2) @(posedge refClk);
        arstN <= 1'h1;
        #1;
        chk("reset", 8'h18, seen & 8'hF8);
        go(1, 0, 8'h03, 8'hE7, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(0, 1, 8'h83, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(1, 0, 8'h83, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(1, 0, 8'h04, 8'hFF, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(0, 1, 8'h04, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[1], 8'h0F, 8'h01, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[1], 8'hFF, 8'h01, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[2], 8'h05, 8'h05, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[2], 8'h00, 8'h01, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[4], 8'h80, 8'h00, 3'h0);
        go(0, 0, 8'h00, 8'h00, 1, ops[5], 8'h01, 8'h00, 3'h0);
        go(1, 0, 8'h03, 8'hFF, 1, ops[3], 8'h00, 8'h00, 3'h0);
        go(0, 0, 8'h00, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h1);
        go(0, 0, 8'h00, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h4);
        go(0, 0, 8'h00, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h2);
        go(0, 0, 8'h00, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h5);
        arstN <= 1'h0;
        repeat (2) @(posedge refClk);
        arstN <= 1'h1;
        #1;
        chk("reset again", 8'h18, seen & 8'hF8);
        {m, mRes} = 16'h1800;
        go(1, 0, 8'h83, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h0);
        go(0, 1, 8'h03, 8'h00, 0, ops[0], 8'h00, 8'h00, 3'h0);
        repeat (400) begin
            seed = xs(seed);
            ev = seed[29] ? 3'(3'h1 << seed[28:27]) : 3'h0;
            go(seed[0] & ~seed[1], seed[1] & ~seed[0],
                seed[2] ? {seed[3], 7'h03} : seed[15:8], seed[26:19],
                seed[4], ops[seed[18:16]], seed[26:19],
                seed[31:24] ^ seed[15:8], ev);
        end
        testDone;
    end
endmodule // tb_sfb_status_flags
